// ===== dv/dmb_phy_model.sv
// External PHY on the management data line
`timescale 1ns/1ps
`default_nettype none
module dmb_phy_model #(
  parameter logic [4:0] PHY_AD = 5'h02 // Own address, nonzero
) (
  input  wire logic mdc,  // Mgmt clock
  input  wire logic mdio, // Line level
  output logic      drv,  // Driving line
  output logic      dout  // Drive value
);
  logic [15:0] mem [32];
  logic [63:0] sh;
  logic [11:0] hd;
  int          n;
  logic        hit;
  assign hit = hd[9:5] == PHY_AD || hd[9:5] == 5'h00;
  initial begin
    n = 0;
    sh = '0;
    drv = 0;
    dout = 0;
    for (int i = 0; i < 32; i++) mem[i] = 16'(i) * 16'h0123;
  end
  // Frame found by its preamble and start pattern, not by the master's enable
  always @(posedge mdc) begin
    sh = {sh[62:0], mdio};
    if (n == 0 && sh[33:0] == {32'hffffffff, 2'b01}) n = 34;
    else if (n != 0) n = n + 1;
    if (n == 46) hd = sh[11:0];
    if (n == 64) begin
      if (hd[11:10] == 2'b01 && hit) mem[hd[4:0]] = sh[15:0];
      n = 0;
    end
  end
  always @(negedge mdc) begin
    drv = hd[11:10] == 2'b10 && hit && n >= 47 && n < 64;
    dout = n == 47 ? 1'b0 : mem[hd[4:0]][63 - n];
  end
endmodule // dmb_phy_model
`default_nettype wire

// ===== dv/dmb_props.sv
// Port-level assertions for the management bridge
`timescale 1ns/1ps
`default_nettype none
module dmb_props
  import dmb_pkg::*;
(
  input wire logic        clk,                 // Clock
  input wire logic        rst,                 // Reset
  input wire logic        reg_wr,              // Write strobe
  input wire logic [1:0]  reg_addr,            // Offset
  input wire logic [31:0] reg_wdata,           // Write data
  input wire logic        host_done_interrupt, // Done pulse
  input wire logic [5:0]  clock_divide,        // Divide setting
  input wire logic        mgmt_clk,            // Mgmt clock
  input wire logic        mgmt_data_out,       // Line value
  input wire logic        mgmt_data_oe_n,      // Line enable
  input wire logic [31:0] host_read_data_pins, // Request pins
  input wire logic        host_mgmt_ready_pin, // Select out
  input wire logic        host_mgmt_select_pin // Data valid
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  logic [9:0] code;
  logic       usr_cmd;
  logic [7:0] half_r;
  assign code = reg_wdata[9:0];
  // Own window decode, so a slip shared with the design still shows
  assign usr_cmd = reg_wr && reg_addr == OFS_COMMAND && !reg_wdata[CMD_WE_BIT]
    && (code <= USER_WIN0_HI || (code >= USER_WIN1_LO && code <= USER_WIN1_HI))
    && !host_mgmt_ready_pin && mgmt_data_oe_n;
  // Cycles since the clock last toggled, saturating
  always_ff @(posedge clk or posedge rst) begin
    if (rst)
      half_r <= 8'hff;
    else
      half_r <= $changed(mgmt_clk) ? 8'h01 : half_r + {7'h0, half_r != 8'hff};
  end
  property p_mdc_half; $changed(mgmt_clk) |-> half_r >= {1'b0, MDC_MIN_HALF}; endproperty
  a_mdc_half: assert property (p_mdc_half) else $error("mdc phase short");
  property p_mdc_off; clock_divide == 6'h0 && !mgmt_clk |=> !mgmt_clk; endproperty
  a_mdc_off: assert property (p_mdc_off) else $error("mdc runs while off");
  property p_start; $fell(mgmt_data_oe_n) |-> mgmt_data_out && !mgmt_clk; endproperty
  a_start: assert property (p_start) else $error("bad frame start");
  property p_shift; !mgmt_data_oe_n && $changed(mgmt_data_out) |-> !mgmt_clk; endproperty
  a_shift: assert property (p_shift) else $error("data moved on high mdc");
  property p_req_enc; usr_cmd |=> host_read_data_pins ==
    {16'h0, 1'b1, HOST_OPC_READ, 3'h0, $past(code)}; endproperty
  a_req_enc: assert property (p_req_enc) else $error("bad request encoding");
  property p_req_src; host_read_data_pins[HREQ_BIT] |-> $past(usr_cmd); endproperty
  a_req_src: assert property (p_req_src) else $error("request without user read");
  property p_usr_done; host_mgmt_ready_pin && host_mgmt_select_pin |->
    ##[1:4] host_done_interrupt; endproperty
  a_usr_done: assert property (p_usr_done) else $error("user read not done");
  property p_done; host_done_interrupt |-> mgmt_data_oe_n && !mgmt_clk
    && !host_mgmt_ready_pin; endproperty
  a_done: assert property (p_done) else $error("done while busy");
endmodule // dmb_props
bind dmb_bridge dmb_props dmb_props_inst (.clk(clk), .rst(rst), .reg_wr(reg_wr),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .host_done_interrupt(host_done_interrupt),
  .clock_divide(clock_divide), .mgmt_clk(mgmt_clk), .mgmt_data_out(mgmt_data_out),
  .mgmt_data_oe_n(mgmt_data_oe_n), .host_read_data_pins(host_read_data_pins),
  .host_mgmt_ready_pin(host_mgmt_ready_pin), .host_mgmt_select_pin(host_mgmt_select_pin));
`default_nettype wire

// ===== dv/tb_top.sv
// Self-checking bench for the management bridge
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import dmb_pkg::*;
  logic        clk = 0, rst = 1, reg_wr = 0, reg_rd = 0, mgmt_enable = 0, was_rd = 0;
  logic [1:0]  reg_addr = 0;
  logic [31:0] reg_wdata = 0, host_write_data_pins = 0, reg_rdata, host_read_data_pins;
  logic [5:0]  clock_divide = 0;
  logic        reg_ack, host_done_interrupt, mgmt_clk, mgmt_data_out, mgmt_data_oe_n;
  logic        pcs_we, host_mgmt_ready_pin, host_mgmt_select_pin = 0, phy_drv, phy_out;
  logic [4:0]  pcs_regad, r, pcs_ad = 5'h05;
  logic [15:0] pcs_wdata, d;
  logic [31:0] ul, uh, seed_v;
  logic [63:0] e;
  logic [63:0] exp_q [$];
  logic [9:0]  codes [4] = '{10'h000, 10'h02f, 10'h040, 10'h04f};
  int          n_errors = 0, tests_run = 0, n_we = 0;
  wire logic   mgmt_data_in = !mgmt_data_oe_n ? mgmt_data_out : (phy_drv ? phy_out : 1'b1);
  wire logic [15:0] pcs_rdata = {pcs_regad, 11'h2a5};
  always #4 clk = ~clk;
  dmb_bridge dmb_bridge_inst (.clk(clk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_ack(reg_ack),
    .host_done_interrupt(host_done_interrupt), .clock_divide(clock_divide),
    .mgmt_enable(mgmt_enable), .mgmt_clk(mgmt_clk), .mgmt_data_out(mgmt_data_out),
    .mgmt_data_oe_n(mgmt_data_oe_n), .mgmt_data_in(mgmt_data_in),
    .internal_slave_phys_address(pcs_ad), .pcs_we(pcs_we), .pcs_regad(pcs_regad),
    .pcs_wdata(pcs_wdata), .pcs_rdata(pcs_rdata), .host_read_data_pins(host_read_data_pins),
    .host_mgmt_ready_pin(host_mgmt_ready_pin), .host_write_data_pins(host_write_data_pins),
    .host_mgmt_select_pin(host_mgmt_select_pin));
  dmb_phy_model dmb_phy_model_inst (.mdc(mgmt_clk), .mdio(mgmt_data_in), .drv(phy_drv),
    .dout(phy_out));
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] want);
    tests_run++;
    if (seen !== want) begin
      n_errors++;
      $display("unexpected at %0t: got %h, wanted %h", $time, seen, want);
    end
  endtask
  task automatic acc(input logic w, input logic [1:0] a, input logic [31:0] v);
    @(negedge clk);
    reg_wr = w;
    reg_rd = !w;
    reg_addr = a;
    reg_wdata = v;
    @(negedge clk);
    reg_wr = 0;
    reg_rd = 0;
  endtask
  task automatic wr(input logic [1:0] a, input logic [31:0] v);
    acc(1'b1, a, v);
  endtask
  task automatic rd(input logic [1:0] a, input logic [31:0] m, input logic [31:0] x);
    exp_q.push_back({m, x});
    acc(1'b0, a, 32'h0);
  endtask
  task automatic wait_done;
    int i;
    for (i = 0; i < 9000 && host_done_interrupt !== 1'b1; i++) @(negedge clk);
    if (i == 9000) chk(32'h0, 32'h1);
  endtask
  task automatic hold(input logic [15:0] v);
    wr(2'h1, {16'h0, v});
    wr(2'h2, {16'h0, 1'b1, 5'h0, CODE_MGMT_WDATA});
  endtask
  task automatic frame(input logic [9:0] low, input logic we);
    wr(2'h1, {22'h0, low});
    wr(2'h2, {16'h0, we, 5'h0, CODE_MGMT_FRAME});
    wait_done;
  endtask
  // Result checker: the acknowledge stands one cycle, so it is looked at mid-cycle
  always @(posedge clk) was_rd <= reg_rd;
  always @(negedge clk) begin
    if (reg_ack === 1'b1 && was_rd === 1'b1) begin
      e = exp_q.pop_front();
      chk(reg_rdata & e[63:32], e[31:0]);
    end
    if (pcs_we === 1'b1) begin
      n_we++;
      chk({11'h0, pcs_regad, pcs_wdata}, {11'h0, 5'h07, d});
    end
  end
  // User logic answering forwarded reads after a random stall
  initial forever begin
    @(posedge clk);
    #1;
    if (host_read_data_pins[HREQ_BIT] === 1'b1) begin
      repeat ($urandom_range(3)) @(negedge clk);
      // Select is only looked at once the request has stood a cycle
      repeat (2) @(negedge clk);
      host_mgmt_select_pin = 1;
      host_write_data_pins = ul;
      @(negedge clk);
      host_mgmt_select_pin = 0;
      host_write_data_pins = uh;
      @(negedge clk);
      host_write_data_pins = ~uh;
    end
  end
  initial begin
    repeat (40000) @(posedge clk);
    chk(32'h0, 32'h1);
    report_and_stop;
  end
  initial begin
    seed_v = $urandom(32'h0a90);
    repeat (2) @(posedge clk);
    @(negedge clk);
    rst = 0;
    mgmt_enable = 1;
    pcs_ad = 5'h05 + 5'($urandom_range(8));
    wr(2'h1, 32'h41);
    wr(2'h2, 32'h83b4);
    repeat (40) @(negedge clk);
    rd(2'h3, 32'hffffffff, 32'h0);
    clock_divide = 6'd30;
    d = 16'($urandom);
    r = 5'h10 | 5'($urandom);
    hold(d);
    frame({5'h02, r}, 1'b1);
    rd(2'h3, 32'h00010008, 32'h00010008);
    frame({5'h02, r}, 1'b0);
    rd(2'h1, 32'hffffffff, {16'h0, d});
    clock_divide = 6'd3;
    d = 16'($urandom);
    hold(d);
    frame({5'h00, 5'h07}, 1'b1);
    frame({5'h02, 5'h07}, 1'b0);
    rd(2'h1, 32'hffffffff, {16'h0, d});
    chk(32'(n_we), 32'h1);
    frame({pcs_ad, 5'h03}, 1'b0);
    rd(2'h1, 32'hffffffff, {16'h0, 5'h03, 11'h2a5});
    foreach (codes[k]) begin
      ul = $urandom;
      uh = $urandom;
      wr(2'h2, {22'h0, codes[k]});
      wait_done;
      rd(2'h3, 32'h00010010, 32'h00010010);
      rd(2'h1, 32'hffffffff, ul);
      rd(2'h0, 32'hffffffff, uh);
    end
    wr(2'h2, 32'h30);
    repeat (10) @(negedge clk);
    rd(2'h2, 32'hffffffff, 32'h30);
    repeat (4) @(negedge clk);
    report_and_stop;
  end
endmodule // tb_top
`default_nettype wire

// ===== hdl/dmb_bridge.sv
// Register bridge to management frames and to user logic reads
// How it works
// - Code 0x3B0 copies low word into hold
// - 0x3B4 with write-enable sends write frame
// - Frame end sets ready bit, pulses done
// - User window reads go out host pins
// - Strobe bit15, opcode 14:13, address 9:0
// - User data captured into high/low words
// - User read done sets stats ready bit
// - Bridge masters frames, shifts with its clock
// - Management clock capped at 2.5 MHz
// - Write frames use opcode 01
// - Read frames use 10, release at turnaround
// - Five-bit phys address, zero is broadcast
// - Five-bit register address field
// - Divider 2*(1+setting), at least 50; zero keeps disabled
// - 0x3B4 without write-enable reads into low
// - Internal slave answers own address or zero
`timescale 1ns/1ps
`default_nettype none
module dmb_bridge
  import dmb_pkg::*;
(
  input  wire logic              clk,                   // Host clock
  input  wire logic              rst,                   // Async reset, active high
  input  wire logic              reg_wr,                // Register write strobe
  input  wire logic              reg_rd,                // Register read strobe
  input  wire logic [1:0]        reg_addr,              // Register offset
  input  wire logic [31:0]       reg_wdata,             // Register write data
  output logic      [31:0]       reg_rdata,             // Register read data
  output logic                   reg_ack,               // Access acknowledge
  output logic                   host_done_interrupt,   // Completion pulse
  input  wire logic [5:0]        clock_divide,          // Management clock divide setting
  input  wire logic              mgmt_enable,           // Management port enable
  output logic                   mgmt_clk,              // Management clock out
  output logic                   mgmt_data_out,         // Data line drive value
  output logic                   mgmt_data_oe_n,        // Data line enable, low drives
  input  wire logic              mgmt_data_in,          // Data line level
  input  wire logic [ADR_W-1:0]  internal_slave_phys_address, // Internal slave address
  output logic                   pcs_we,                // Internal slave write pulse
  output logic      [ADR_W-1:0]  pcs_regad,             // Internal slave register select
  output logic      [DATA_W-1:0] pcs_wdata,             // Internal slave write data
  input  wire logic [DATA_W-1:0] pcs_rdata,             // Internal slave read data
  output logic      [31:0]       host_read_data_pins,   // Forwarded request encoding
  output logic                   host_mgmt_ready_pin,   // Select indication to user
  input  wire logic [31:0]       host_write_data_pins,  // Data from user logic
  input  wire logic              host_mgmt_select_pin   // User data valid
);

  function automatic logic in_user_window(input logic [CODE_W-1:0] code);
    in_user_window = (code >= USER_WIN0_LO && code <= USER_WIN0_HI) ||
                     (code >= USER_WIN1_LO && code <= USER_WIN1_HI);
  endfunction

  dmb_regs_t       st_r;
  dmb_regs_t       st_nxt;
  logic [6:0]      half_len;
  logic            mgmt_on;
  logic            tick;
  logic [CODE_W-1:0] wcode;
  logic            wwe;
  logic            cmd_wr;
  logic [ADR_W-1:0] f_phy;
  logic [ADR_W-1:0] f_reg;
  logic            rx_bit;
  logic [5:0]      nbit;

  // A small setting is stretched so the clock never exceeds its ceiling
  always_comb begin
    half_len = {1'b0, clock_divide} + DIV_ONE;
    if (half_len < MDC_MIN_HALF) begin
      half_len = MDC_MIN_HALF;
    end
  end

  assign mgmt_on = mgmt_enable && (clock_divide != '0);
  assign tick    = (st_r.div_cnt == half_len - DIV_ONE);
  assign wcode   = reg_wdata[CODE_W-1:0];
  assign wwe     = reg_wdata[CMD_WE_BIT];
  assign cmd_wr  = reg_wr && (reg_addr == OFS_COMMAND);
  assign f_phy   = st_r.lo_word[PHYAD_LSB +: ADR_W];
  assign f_reg   = st_r.lo_word[REGAD_LSB +: ADR_W];
  // Reads aimed at the internal slave come from it, not from the pin
  assign rx_bit  = st_r.frame_internal ? pcs_rdata[DATA_W-1 - (st_r.bit_cnt - BIT_DATA)]
                                       : mgmt_data_in;
  assign nbit    = st_r.bit_cnt + 6'h01;

  always_comb begin
    st_nxt          = st_r;
    st_nxt.ack      = 1'b0;
    st_nxt.done_irq = 1'b0;
    st_nxt.pcs_we   = 1'b0;
    st_nxt.host_rd[HREQ_BIT] = 1'b0;

    // Register bus
    if (reg_rd || reg_wr) begin
      st_nxt.ack = 1'b1;
    end
    if (reg_rd) begin
      case (reg_addr)
        OFS_HIGH_WORD: st_nxt.rdata = st_r.hi_word;
        OFS_LOW_WORD:  st_nxt.rdata = st_r.lo_word;
        OFS_COMMAND:   st_nxt.rdata = st_r.cmd;
        OFS_READY: begin
          st_nxt.rdata = '0;
          st_nxt.rdata[RDY_ANY_BIT]   = st_r.rdy_any;
          st_nxt.rdata[RDY_MGMT_BIT]  = st_r.rdy_mgmt;
          st_nxt.rdata[RDY_STATS_BIT] = st_r.rdy_stats;
        end
        default: st_nxt.rdata = '0;
      endcase
    end
    if (reg_wr && reg_addr == OFS_HIGH_WORD) begin
      st_nxt.hi_word = reg_wdata;
    end
    if (reg_wr && reg_addr == OFS_LOW_WORD) begin
      st_nxt.lo_word = reg_wdata;
    end

    // Commands are taken only while idle; a busy bridge ignores them
    if (cmd_wr && st_r.state == S_IDLE) begin
      st_nxt.cmd = reg_wdata;
      if (wcode == CODE_MGMT_WDATA) begin
        st_nxt.wdata_hold = st_r.lo_word[DATA_W-1:0];
      end else if (wcode == CODE_MGMT_FRAME && mgmt_on) begin
        st_nxt.rdy_any    = 1'b0;
        st_nxt.rdy_mgmt   = 1'b0;
        st_nxt.state      = S_FRAME;
        st_nxt.frame_read = !wwe;
        // Write data comes from the hold, never from the address word
        st_nxt.frame = {PREAMBLE, START_PAT,
                        wwe ? OP_WRITE : OP_READ,
                        f_phy, f_reg, TA_WRITE,
                        st_r.wdata_hold};
        st_nxt.frame_internal = (f_phy == internal_slave_phys_address) ||
                                (f_phy == PHYAD_BCAST);
        st_nxt.pcs_regad  = f_reg;
        st_nxt.pcs_wdata  = st_r.wdata_hold;
        st_nxt.bit_cnt    = '0;
        st_nxt.div_cnt    = '0;
        st_nxt.mdc        = 1'b0;
        st_nxt.mdio_out   = PREAMBLE[31];
        st_nxt.mdio_oe_n  = 1'b0;
      end else if (in_user_window(wcode) && !wwe) begin
        st_nxt.rdy_any   = 1'b0;
        st_nxt.rdy_stats = 1'b0;
        st_nxt.state     = S_HOST_REQ;
        st_nxt.host_rd   = '0;
        st_nxt.host_rd[HREQ_BIT] = 1'b1;
        st_nxt.host_rd[HOPC_LSB +: 2] = HOST_OPC_READ;
        st_nxt.host_rd[CODE_W-1:0] = wcode;
        st_nxt.host_sel  = 1'b1;
      end
    end

    case (st_r.state)
      S_IDLE: begin
        // A frame launched this cycle must drive its first preamble bit
        if (st_nxt.state == S_IDLE) begin
          st_nxt.mdio_oe_n = 1'b1;
        end
      end
      S_FRAME: begin
        if (tick) begin
          st_nxt.div_cnt = '0;
          st_nxt.mdc     = !st_r.mdc;
          if (!st_r.mdc) begin
            // Rising edge: sample the slave's data bits during a read
            if (st_r.frame_read && st_r.bit_cnt >= BIT_DATA) begin
              st_nxt.rd_shift = {st_r.rd_shift[DATA_W-2:0], rx_bit};
            end
          end else if (st_r.bit_cnt == BIT_LAST) begin
            st_nxt.state     = S_IDLE;
            st_nxt.mdio_oe_n = 1'b1;
            st_nxt.mdio_out  = 1'b1;
            st_nxt.rdy_any   = 1'b1;
            st_nxt.rdy_mgmt  = 1'b1;
            st_nxt.done_irq  = 1'b1;
            if (st_r.frame_read) begin
              st_nxt.lo_word = {{(32-DATA_W){1'b0}}, st_r.rd_shift};
            end else if (st_r.frame_internal) begin
              st_nxt.pcs_we = 1'b1;
            end
          end else begin
            // Falling edge: present the next bit, MSB first
            st_nxt.bit_cnt   = nbit;
            st_nxt.frame     = {st_r.frame[FRAME_BITS-2:0], 1'b0};
            st_nxt.mdio_out  = st_r.frame[FRAME_BITS-2];
            st_nxt.mdio_oe_n = st_r.frame_read && (nbit >= BIT_TA);
          end
        end else begin
          st_nxt.div_cnt = st_r.div_cnt + DIV_ONE;
        end
      end
      S_HOST_REQ: begin
        st_nxt.state = S_HOST_WAIT;
      end
      S_HOST_WAIT: begin
        if (host_mgmt_select_pin) begin
          st_nxt.lo_word = host_write_data_pins;
          st_nxt.state   = S_HOST_MSW;
        end
      end
      S_HOST_MSW: begin
        // Second data beat carries the upper word
        st_nxt.hi_word   = host_write_data_pins;
        st_nxt.host_sel  = 1'b0;
        st_nxt.state     = S_IDLE;
        st_nxt.rdy_any   = 1'b1;
        st_nxt.rdy_stats = 1'b1;
        st_nxt.done_irq  = 1'b1;
      end
      default: begin
        st_nxt.state = S_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_r           <= '0;
      st_r.state     <= S_IDLE;
      st_r.mdio_out  <= 1'b1;
      st_r.mdio_oe_n <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign reg_rdata           = st_r.rdata;
  assign reg_ack             = st_r.ack;
  assign host_done_interrupt = st_r.done_irq;
  assign mgmt_clk            = st_r.mdc;
  assign mgmt_data_out       = st_r.mdio_out;
  assign mgmt_data_oe_n      = st_r.mdio_oe_n;
  assign pcs_we              = st_r.pcs_we;
  assign pcs_regad           = st_r.pcs_regad;
  assign pcs_wdata           = st_r.pcs_wdata;
  assign host_read_data_pins = st_r.host_rd;
  assign host_mgmt_ready_pin = st_r.host_sel;

endmodule // dmb_bridge
`default_nettype wire

// ===== hdl/dmb_pkg.sv
// Constants, types and state record of the management bridge
package dmb_pkg;
  // Register offsets from the bridge base address
  localparam logic [1:0] OFS_HIGH_WORD = 2'h0;
  localparam logic [1:0] OFS_LOW_WORD  = 2'h1;
  localparam logic [1:0] OFS_COMMAND   = 2'h2;
  localparam logic [1:0] OFS_READY     = 2'h3;
  // Address codes carried in the command register
  localparam int         CODE_W          = 10;
  localparam logic [9:0] CODE_MGMT_WDATA = 10'h3b0;
  localparam logic [9:0] CODE_MGMT_FRAME = 10'h3b4;
  localparam logic [9:0] USER_WIN0_LO    = 10'h000;
  localparam logic [9:0] USER_WIN0_HI    = 10'h02f;
  localparam logic [9:0] USER_WIN1_LO    = 10'h040;
  localparam logic [9:0] USER_WIN1_HI    = 10'h04f;
  localparam int         CMD_WE_BIT      = 15;
  // Ready status bits
  localparam int RDY_ANY_BIT   = 16;
  localparam int RDY_MGMT_BIT  = 3;
  localparam int RDY_STATS_BIT = 4;
  // Frame addressing fields inside the low data word
  localparam int ADR_W     = 5;
  localparam int REGAD_LSB = 0;
  localparam int PHYAD_LSB = 5;
  localparam int DATA_W    = 16;
  localparam logic [4:0] PHYAD_BCAST = 5'h00;
  // Frame layout, most significant bit first
  localparam logic [31:0] PREAMBLE   = 32'hffffffff;
  localparam logic [1:0]  START_PAT  = 2'b01;
  localparam logic [1:0]  OP_WRITE   = 2'b01;
  localparam logic [1:0]  OP_READ    = 2'b10;
  localparam logic [1:0]  TA_WRITE   = 2'b10;
  localparam logic [5:0]  BIT_TA     = 6'h2e;
  localparam logic [5:0]  BIT_DATA   = 6'h30;
  localparam logic [5:0]  BIT_LAST   = 6'h3f;
  localparam int          FRAME_BITS = 64;
  // Host pin encoding of a forwarded read
  localparam int         HREQ_BIT      = 15;
  localparam int         HOPC_LSB      = 13;
  localparam logic [1:0] HOST_OPC_READ = 2'h3;
  // Management clock limits
  localparam int CLK_HZ     = 125000000;
  localparam int MDC_MAX_HZ = 2500000;
  localparam int MDC_MIN_HALF_I = (CLK_HZ + 2 * MDC_MAX_HZ - 1) / (2 * MDC_MAX_HZ);
  localparam logic [6:0] MDC_MIN_HALF = MDC_MIN_HALF_I[6:0];
  localparam logic [6:0] DIV_ONE      = 7'h01;

  typedef enum logic [2:0] {
    S_IDLE, S_FRAME, S_HOST_REQ, S_HOST_WAIT, S_HOST_MSW
  } dmb_state_t;

  typedef struct packed {
    dmb_state_t                   state;
    logic [31:0]                  hi_word;
    logic [31:0]                  lo_word;
    logic [31:0]                  cmd;
    logic [DATA_W-1:0]            wdata_hold;
    logic                         rdy_any;
    logic                         rdy_mgmt;
    logic                         rdy_stats;
    logic [31:0]                  rdata;
    logic                         ack;
    logic                         done_irq;
    logic [6:0]                   div_cnt;
    logic                         mdc;
    logic                         mdio_out;
    logic                         mdio_oe_n;
    logic [5:0]                   bit_cnt;
    logic [FRAME_BITS-1:0]        frame;
    logic                         frame_read;
    logic                         frame_internal;
    logic [DATA_W-1:0]            rd_shift;
    logic [31:0]                  host_rd;
    logic                         host_sel;
    logic                         pcs_we;
    logic [ADR_W-1:0]             pcs_regad;
    logic [DATA_W-1:0]            pcs_wdata;
  } dmb_regs_t;
endpackage
